// ===== rtl/svdc_pkg.sv
// constants for the supply voltage detect control block
package svdc_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTCTL = 8'h04;
    localparam logic [7:0] ADDR_FLAG = 8'h08;
    localparam logic [7:0] ADDR_IE = 8'h0c;
    localparam logic [7:0] ADDR_PRIO = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;

    // voltage_detect_control fields
    localparam int CTRL_TRIP_LSB = 0;
    localparam int CTRL_TRIP_MSB = 3;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_RSTABLE_BIT = 5;
    localparam int CTRL_BGSTABLE_BIT = 6;
    localparam int CTRL_DIR_BIT = 7;
    localparam logic [7:0] CTRL_WMASK = 8'h9f;

    // interrupt_control fields
    localparam int INTCTL_GIE_BIT = 7;
    localparam int INTCTL_PEIE_BIT = 6;

    // detect bit in flag, enable and priority registers
    localparam int DET_BIT = 2;

    // sticky event status and mask fields
    localparam int ST_DETECT_BIT = 0;
    localparam int ST_REFRDY_BIT = 1;
    localparam int ST_WIDTH = 2;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic IE_RST = 1'b0;
    localparam logic PRIO_RST = 1'b0;
    localparam logic [1:0] ST_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // trip select code that routes the external input to the comparator
    localparam logic [3:0] TRIP_EXTERNAL = 4'hf;

    // reference start-up interval, fixed in time not in clocks
    localparam int STARTUP_NS = 20000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STARTUP_CYCLES =
        (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // shared reference state
    typedef enum logic [1:0] {
        REF_OFF = 2'b00,
        REF_WARM = 2'b01,
        REF_READY = 2'b10
    } svdc_ref_e;

endpackage : svdc_pkg

// ===== rtl/svdc_sync.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/100ps
module svdc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] D,
    output logic [WIDTH-1:0] Q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } svdc_sync_s;

    svdc_sync_s r;
    svdc_sync_s next_r;

    // first stage feeds only the second stage
    always_comb begin
        next_r = r;
        next_r.meta = D;
        next_r.stable = r.meta;
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign Q = r.stable;

endmodule : svdc_sync

// ===== rtl/svdc_top.sv
// supply voltage detect control: apb registers, start-up gate, flag
`timescale 1ns/100ps

module svdc_top #(
    parameter int STARTUP_CYCLES = svdc_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // analog side
    input wire logic CMP_OUT,
    input wire logic REF_OTHER_USERS,
    output logic DETECTOR_ON,
    output logic [3:0] TRIP_SELECT,
    output logic EXT_INPUT_SELECT,
    output logic DETECT_DIRECTION,
    // processor side
    output logic INT_REQ,
    output logic INT_PRIORITY_HIGH,
    output logic WAKE,
    output logic IRQ
);

    localparam int CW = 16;
    localparam logic [CW-1:0] LAST_COUNT = CW'(STARTUP_CYCLES - 1);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] intctl;
        logic flag;
        logic ie;
        logic prio;
        logic [1:0] status;
        logic [1:0] mask;
        svdc_pkg::svdc_ref_e ref_state;
        logic [CW-1:0] count;
        logic en_seen;
        logic ref_stable;
        logic [7:0] rdata;
        logic ready;
        logic slverr;
        logic int_req;
        logic prio_out;
        logic wake;
        logic irq;
        logic det_on;
        logic [3:0] trip;
        logic ext_sel;
        logic dir;
    } svdc_top_s;

    svdc_top_s r;
    svdc_top_s next_r;

    logic [1:0] sync_in;
    logic [1:0] sync_out;
    logic cmp_s;
    logic other_s;

    assign sync_in = {REF_OTHER_USERS, CMP_OUT};

    svdc_sync #(
        .WIDTH(2)
    ) u_sync (
        .MCLK(MCLK),
        .RESET(RESET),
        .D(sync_in),
        .Q(sync_out)
    );

    assign cmp_s = sync_out[0];
    assign other_s = sync_out[1];

    // read data for one address, zero for unmapped
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input svdc_top_s s
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            svdc_pkg::ADDR_CTRL: begin
                v = s.ctrl;
                v[svdc_pkg::CTRL_RSTABLE_BIT] = s.ref_stable;
                v[svdc_pkg::CTRL_BGSTABLE_BIT] =
                    (s.ref_state == svdc_pkg::REF_READY);
            end
            svdc_pkg::ADDR_INTCTL: v = s.intctl;
            svdc_pkg::ADDR_FLAG: v[svdc_pkg::DET_BIT] = s.flag;
            svdc_pkg::ADDR_IE: v[svdc_pkg::DET_BIT] = s.ie;
            svdc_pkg::ADDR_PRIO: v[svdc_pkg::DET_BIT] = s.prio;
            svdc_pkg::ADDR_STATUS: v[1:0] = s.status;
            svdc_pkg::ADDR_MASK: v[1:0] = s.mask;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    function automatic logic mapped(input logic [7:0] addr);
        logic m;
        m = 1'b0;
        case (addr)
            svdc_pkg::ADDR_CTRL,
            svdc_pkg::ADDR_INTCTL,
            svdc_pkg::ADDR_FLAG,
            svdc_pkg::ADDR_IE,
            svdc_pkg::ADDR_PRIO,
            svdc_pkg::ADDR_STATUS,
            svdc_pkg::ADDR_MASK: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction : mapped

    always_comb begin
        logic setup;
        logic access;
        logic wr;
        logic rd;
        logic lane0;
        logic en;
        logic ref_on;
        logic hit;
        logic set_flag;
        logic [1:0] ev;
        logic [7:0] wd;

        next_r = r;
        setup = PSEL && !PENABLE;
        access = PSEL && PENABLE && r.ready;
        wr = access && PWRITE && !r.slverr;
        rd = access && !PWRITE && !r.slverr;
        lane0 = PSTRB[0];
        wd = PWDATA[7:0];
        en = r.ctrl[svdc_pkg::CTRL_EN_BIT];
        ev = 2'h0;
        ref_on = 1'b0;
        hit = 1'b0;
        set_flag = 1'b0;

        // zero-wait slave: answer prepared in setup, given in access
        next_r.ready = setup;
        if (setup) begin
            next_r.slverr = !mapped(PADDR);
            next_r.rdata = read_mux(PADDR, r);
        end else if (access) begin
            next_r.slverr = 1'b0;
            next_r.rdata = 8'h00;
        end

        // register writes; configuration ordering is up to software
        if (wr && lane0) begin
            case (PADDR)
                svdc_pkg::ADDR_CTRL: begin
                    next_r.ctrl = wd & svdc_pkg::CTRL_WMASK;
                end
                svdc_pkg::ADDR_INTCTL: next_r.intctl = wd;
                svdc_pkg::ADDR_FLAG: begin
                    next_r.flag = wd[svdc_pkg::DET_BIT];
                end
                svdc_pkg::ADDR_IE: next_r.ie = wd[svdc_pkg::DET_BIT];
                svdc_pkg::ADDR_PRIO: next_r.prio = wd[svdc_pkg::DET_BIT];
                svdc_pkg::ADDR_MASK: next_r.mask = wd[1:0];
                default: next_r.mask = next_r.mask;
            endcase
        end

        // shared reference warm-up, counted in fixed time
        ref_on = en || other_s;
        case (r.ref_state)
            svdc_pkg::REF_OFF: begin
                next_r.count = '0;
                if (ref_on) begin
                    next_r.ref_state = svdc_pkg::REF_WARM;
                end
            end
            svdc_pkg::REF_WARM: begin
                if (!ref_on) begin
                    next_r.ref_state = svdc_pkg::REF_OFF;
                    next_r.count = '0;
                end else if (r.count == LAST_COUNT) begin
                    next_r.ref_state = svdc_pkg::REF_READY;
                end else begin
                    next_r.count = r.count + 1'b1;
                end
            end
            svdc_pkg::REF_READY: begin
                if (!ref_on) begin
                    next_r.ref_state = svdc_pkg::REF_OFF;
                    next_r.count = '0;
                end
            end
            default: begin
                next_r.ref_state = svdc_pkg::REF_OFF;
                next_r.count = '0;
            end
        endcase

        // stable status drops on disable and on every new enable
        next_r.en_seen = en;
        next_r.ref_stable = en && r.en_seen
            && (r.ref_state == svdc_pkg::REF_READY);

        // comparator high means scaled supply at or above reference
        hit = r.dir ? cmp_s : !cmp_s;
        set_flag = en && r.ref_stable && hit;
        if (set_flag) begin
            next_r.flag = 1'b1;
        end
        ev[svdc_pkg::ST_DETECT_BIT] = set_flag && !r.flag;
        ev[svdc_pkg::ST_REFRDY_BIT] = next_r.ref_stable && !r.ref_stable;

        // sticky status, cleared by a read, a new event wins
        // clear only what the read reported, so a late event survives
        if (rd && PADDR == svdc_pkg::ADDR_STATUS) begin
            next_r.status = r.status & ~r.rdata[1:0];
        end
        next_r.status = next_r.status | ev;

        // registered outputs
        next_r.det_on = next_r.ctrl[svdc_pkg::CTRL_EN_BIT];
        next_r.trip = next_r.ctrl[svdc_pkg::CTRL_TRIP_MSB:
                                  svdc_pkg::CTRL_TRIP_LSB];
        next_r.ext_sel =
            (next_r.trip == svdc_pkg::TRIP_EXTERNAL);
        next_r.dir = next_r.ctrl[svdc_pkg::CTRL_DIR_BIT];
        next_r.wake = next_r.flag && next_r.ie;
        next_r.int_req = next_r.flag && next_r.ie
            && next_r.intctl[svdc_pkg::INTCTL_GIE_BIT];
        next_r.prio_out = next_r.prio;
        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            r <= '0;
            r.ctrl <= svdc_pkg::CTRL_RST;
            r.intctl <= svdc_pkg::INTCTL_RST;
            r.flag <= svdc_pkg::FLAG_RST;
            r.ie <= svdc_pkg::IE_RST;
            r.prio <= svdc_pkg::PRIO_RST;
            r.status <= svdc_pkg::ST_RST;
            r.mask <= svdc_pkg::MASK_RST;
            r.ref_state <= svdc_pkg::REF_OFF;
        end else begin
            r <= next_r;
        end
    end

    assign PRDATA = {24'h000000, r.rdata};
    assign PREADY = r.ready;
    assign PSLVERR = r.slverr;
    assign DETECTOR_ON = r.det_on;
    assign TRIP_SELECT = r.trip;
    assign EXT_INPUT_SELECT = r.ext_sel;
    assign DETECT_DIRECTION = r.dir;
    assign INT_REQ = r.int_req;
    assign INT_PRIORITY_HIGH = r.prio_out;
    assign WAKE = r.wake;
    assign IRQ = r.irq;

    // only a flag register write can raise the flag while the stable status is low
    chk_flag_gated: assert property (
        @(posedge MCLK) disable iff (RESET)
        (!r.flag && !r.ref_stable && !(PSEL && PENABLE && PWRITE
            && PADDR == svdc_pkg::ADDR_FLAG)) |=> !r.flag
    ) else $error("detect flag set before reference stable");

    // warm-up never ends early
    chk_warm_length: assert property (
        @(posedge MCLK) disable iff (RESET)
        (r.ref_state == svdc_pkg::REF_READY
            && $past(r.ref_state) == svdc_pkg::REF_WARM)
        |-> $past(r.count) == LAST_COUNT
    ) else $error("reference ready after wrong count");

    // a disabled detector reports no stable reference
    chk_disable_clear: assert property (
        @(posedge MCLK) disable iff (RESET)
        !r.ctrl[svdc_pkg::CTRL_EN_BIT] |=> !r.ref_stable
    ) else $error("stable status held while disabled");

    // fresh enable always starts with stable low
    chk_enable_restart: assert property (
        @(posedge MCLK) disable iff (RESET)
        $rose(r.ctrl[svdc_pkg::CTRL_EN_BIT]) |-> !r.ref_stable
    ) else $error("stable status not cleared on enable");

    // a qualifying comparator level sets the flag next cycle
    chk_detect_sets: assert property (
        @(posedge MCLK) disable iff (RESET)
        (r.ctrl[svdc_pkg::CTRL_EN_BIT] && r.ref_stable
            && (r.dir ? cmp_s : !cmp_s)) |=> r.flag
    ) else $error("comparator match did not set flag");

    // flag stays until software writes the flag register
    chk_flag_sticky: assert property (
        @(posedge MCLK) disable iff (RESET)
        (r.flag && !(PSEL && PENABLE && PWRITE
            && PADDR == svdc_pkg::ADDR_FLAG)) |=> r.flag
    ) else $error("detect flag lost without a clear");

    // request only with detect and global enables
    chk_int_qual: assert property (
        @(posedge MCLK) disable iff (RESET)
        INT_REQ |-> (r.flag && r.ie
            && r.intctl[svdc_pkg::INTCTL_GIE_BIT])
    ) else $error("interrupt request without enables");

    // wake without global enable resumes in line, no request
    chk_wake_inline: assert property (
        @(posedge MCLK) disable iff (RESET)
        (WAKE && !r.intctl[svdc_pkg::INTCTL_GIE_BIT]) |-> !INT_REQ
    ) else $error("vectoring while globally disabled");

    // external code selects the external input
    chk_ext_select: assert property (
        @(posedge MCLK) disable iff (RESET)
        EXT_INPUT_SELECT == (TRIP_SELECT == svdc_pkg::TRIP_EXTERNAL)
    ) else $error("external input select mismatch");

    // every access phase ends in a single cycle
    chk_apb_ready: assert property (
        @(posedge MCLK) disable iff (RESET)
        (PSEL && !PENABLE) |=> PREADY ##1 !PREADY
    ) else $error("apb access not answered in one cycle");

endmodule : svdc_top

// ===== tb/svdc_top_tb_top.sv
// self-checking bench for the supply voltage detect control block
`timescale 1ns/100ps
module svdc_top_tb_top;
    // short start-up so the warm-up fits a brief run
    localparam int SU = 16;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic cmp = 1'b1;
    logic oth = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, det_on, ext_sel, dir, int_req, prio, wake, irq;
    logic [3:0] trip;
    logic [3:0] cv;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int comparisons = 0;
    int n;

    svdc_top #(.STARTUP_CYCLES(SU)) u_dut (
        .MCLK(mclk), .RESET(reset),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CMP_OUT(cmp), .REF_OTHER_USERS(oth),
        .DETECTOR_ON(det_on), .TRIP_SELECT(trip),
        .EXT_INPUT_SELECT(ext_sel), .DETECT_DIRECTION(dir),
        .INT_REQ(int_req), .INT_PRIORITY_HIGH(prio), .WAKE(wake), .IRQ(irq)
    );

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; waits for pready, never a fixed count
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] s);
        int k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // pready read before this edge updates it, as the slave sees it
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) begin
                num_errors++;
                report_and_stop();
            end
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hf);
    endtask : wr

    // read, ignoring the bandgap-ready bit of the control register
    task automatic rc(input string what, input logic [7:0] a,
            input logic [7:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        if (a == svdc_pkg::ADDR_CTRL) begin
            rd[6] = exp[6];
        end
        chk(what, {24'h0, exp}, rd);
    endtask : rc

    task automatic drive(input logic c, input logic o);
        @(posedge mclk);
        cmp <= c;
        oth <= o;
    endtask : drive

    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        for (int a = 0; a < 8'h1c; a += 4) begin
            rc("reset value", a[7:0], 8'h00);
        end
        chk("detector on", 0, det_on);
        bus(1'b1, 8'h40, 32'hff, 4'hf);
        chk("unmapped write error", 1, err);
        bus(1'b0, 8'h40, 32'h0, 4'hf);
        chk("unmapped read", 32'h1, {rd[31:1], err});
        bus(1'b1, svdc_pkg::ADDR_IE, 32'h04, 4'h0);
        rc("strobe off", svdc_pkg::ADDR_IE, 8'h00);
        chk("mapped error", 0, err);
        // every trip code of the documented range, direction taken from code bit 0
        for (int c = 8; c < 16; c++) begin
            cv = c[3:0];
            wr(svdc_pkg::ADDR_CTRL, {cv[0], 3'b000, cv});
            settle(1);
            chk("trip select", {28'h0, cv}, {28'h0, trip});
            chk("direction", {31'h0, cv[0]}, {31'h0, dir});
            chk("external", {31'h0, cv == 4'hf}, {31'h0, ext_sel});
        end
        // warm-up: an excursion while the reference settles is lost
        wr(svdc_pkg::ADDR_MASK, 8'h02);
        wr(svdc_pkg::ADDR_CTRL, 8'h08);
        wr(svdc_pkg::ADDR_CTRL, 8'h18);
        drive(1'b0, 1'b0);
        repeat (3) @(posedge mclk);
        drive(1'b1, 1'b0);
        rc("stable early", svdc_pkg::ADDR_CTRL, 8'h18);
        rc("flag in warm-up", svdc_pkg::ADDR_FLAG, 8'h00);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk("startup span", 1, n >= 1 && n <= SU);
        chk("detector on", 1, det_on);
        rc("flag after warm-up", svdc_pkg::ADDR_FLAG, 8'h00);
        rc("ready event", svdc_pkg::ADDR_STATUS, 8'h02);
        rc("status cleared", svdc_pkg::ADDR_STATUS, 8'h00);
        settle(1);
        chk("irq cleared", 0, irq);
        // falling supply matches, interrupt paths
        wr(svdc_pkg::ADDR_IE, 8'h04);
        wr(svdc_pkg::ADDR_MASK, 8'h01);
        wr(svdc_pkg::ADDR_PRIO, 8'h04);
        drive(1'b0, 1'b0);
        settle(5);
        chk("wake", 1, wake);
        chk("request no global", 0, int_req);
        chk("irq event", 1, irq);
        chk("priority", 1, prio);
        wr(svdc_pkg::ADDR_INTCTL, 8'h80);
        settle(1);
        chk("request global", 1, int_req);
        wr(svdc_pkg::ADDR_IE, 8'h00);
        settle(1);
        chk("request no enable", 0, int_req);
        drive(1'b1, 1'b0);
        settle(4);
        rc("flag latched", svdc_pkg::ADDR_FLAG, 8'h04);
        wr(svdc_pkg::ADDR_FLAG, 8'h00);
        rc("flag cleared", svdc_pkg::ADDR_FLAG, 8'h00);
        wr(svdc_pkg::ADDR_MASK, 8'h00);
        settle(1);
        chk("irq masked", 0, irq);
        rc("detect event", svdc_pkg::ADDR_STATUS, 8'h01);
        // disable drops stable; shared reference skips the warm-up
        drive(1'b1, 1'b1);
        wr(svdc_pkg::ADDR_CTRL, 8'h08);
        settle(1);
        chk("detector off", 0, det_on);
        rc("stable off", svdc_pkg::ADDR_CTRL, 8'h08);
        wr(svdc_pkg::ADDR_CTRL, 8'h88);
        wr(svdc_pkg::ADDR_CTRL, 8'h98);
        settle(3);
        rc("shared ready", svdc_pkg::ADDR_CTRL, 8'hb8);
        settle(5);
        rc("rise detect", svdc_pkg::ADDR_FLAG, 8'h04);
        drive(1'b0, 1'b0);
        wr(svdc_pkg::ADDR_FLAG, 8'h00);
        wr(svdc_pkg::ADDR_CTRL, 8'h88);
        wr(svdc_pkg::ADDR_CTRL, 8'h98);
        rc("restart warm-up", svdc_pkg::ADDR_CTRL, 8'h98);
        // reset in mid-run
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        settle(1);
        chk("off after reset", 0, {det_on, dir, wake, int_req});
        rc("ctrl after reset", svdc_pkg::ADDR_CTRL, 8'h00);
        report_and_stop();
    end
endmodule : svdc_top_tb_top
